/* design/ipcirq_pkg.sv */
// Purpose: constants and types for the two-slot carrier interrupt control
// Assumes: one 10 MHz core clock, synchronous active-high reset
// Notes: offsets are byte offsets within the A16 window of the carrier
// Operation
// - Selector positions 0..7 provide level and control registers per slot.
// - Selector positions 8..F disable both registers per slot.
// - Disabled: offsets C0..FF route to that slot's identification space.
// - Level register: bits 2:0 first line, bits 6:4 second line, read/write.
// - Lowest field bit is the level LSB, highest the MSB.
// - Level 000 blocks the module line from any bus request.
// - Level 001..111 drives bus request IRQ1..IRQ7 equal to the value.
// - Level fields reset to the selector's predefined mapping.
// - Registers answer only in A16 space with selector 0..7.
// - Writing 1 to control bit 7 starts a slot module reset; resets to 0.
// - Reset bit reads 1 while module reset runs, clears itself after.
// - Control bit 2 reads the module error signal; reset value 0.
// - Control bits 1 and 0 read second and first line pending; reset 0.
// - Level registers at 0x01C1 (second slot) and 0x00C1 (first slot).
// - Control registers at 0x00C3 (first slot) and 0x01C3 (second slot).

package ipcirq_pkg;
	// =========================================================
	// register map
	localparam logic [8:0] OFS_SLOT_A_LEVEL = 9'h0C1;
	localparam logic [8:0] OFS_SLOT_A_CTRL = 9'h0C3;
	localparam logic [8:0] OFS_SLOT_B_LEVEL = 9'h1C1;
	localparam logic [8:0] OFS_SLOT_B_CTRL = 9'h1C3;
	localparam logic [7:0] OFS_REG_LO = 8'hC0;
	localparam logic [7:0] OFS_REG_HI = 8'hFF;
	localparam logic [7:0] OFS_ID_LO = 8'h80;
	// =========================================================
	// field positions
	localparam int FLD_FIRST_LSB = 0;
	localparam int FLD_SECOND_LSB = 4;
	localparam int BIT_RESET = 7;
	localparam int BIT_ERROR = 2;
	localparam int BIT_PEND_SECOND = 1;
	localparam int BIT_PEND_FIRST = 0;
	localparam logic [7:0] LEVEL_WMASK = 8'h77;
	localparam logic [7:0] CTRL_RESET_VAL = 8'h00;
	localparam logic [3:0] RSV_FILL = 4'h0;
	// =========================================================
	// timing: module reset pulse length (no figure printed)
	localparam int MOD_RESET_NS = 1000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int MOD_RESET_CYC = (MOD_RESET_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// =========================================================
	// types
	typedef logic [2:0] ipcirq_level_t;
	typedef struct packed {
		ipcirq_level_t second;
		ipcirq_level_t first;
	} ipcirq_map_s;
	typedef struct packed {
		logic [1:0] irq;
		logic error;
	} ipcirq_mod_s;
	typedef enum logic [1:0] {
		RST_IDLE = 2'b01,
		RST_BUSY = 2'b10
	} ipcirq_rst_e;

	// predefined mapping for selector (low three bits), one slot
	function automatic ipcirq_map_s ipcirq_preset(input logic [2:0] sel,
		input logic slot_b);
		ipcirq_map_s m;
		m = '0;
		case ({slot_b, sel})
			4'h1: m = '{second: 3'h2, first: 3'h1};
			4'h2: m = '{second: 3'h5, first: 3'h4};
			4'h3: m = '{second: 3'h4, first: 3'h6};
			4'h4: m = '{second: 3'h1, first: 3'h1};
			4'h9: m = '{second: 3'h4, first: 3'h3};
			4'hA: m = '{second: 3'h1, first: 3'h2};
			4'hB: m = '{second: 3'h1, first: 3'h3};
			4'hC: m = '{second: 3'h2, first: 3'h2};
			default: m = '0;
		endcase
		return m;
	endfunction : ipcirq_preset
endpackage : ipcirq_pkg

/* design/ipcirq_slot.sv */
// Purpose: one mezzanine slot: level register, reset sequencer, status
// Assumes: module inputs already synchronised
// Notes: module reset pulse length is MOD_RESET_CYC
`timescale 1ns/10ps
`default_nettype none
module ipcirq_slot
	import ipcirq_pkg::*;
#(
	parameter int RESET_CYC = MOD_RESET_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// configuration
	input wire ipcirq_map_s preset,
	// register access
	input wire logic level_wr,
	input wire logic ctrl_wr,
	input wire logic [7:0] wdata,
	// module side
	input wire ipcirq_mod_s mod_in,
	output logic mod_reset,
	// results
	output ipcirq_map_s level,
	output logic [7:0] ctrl_rd,
	output logic [7:0] req_lines
);
	// =========================================================
	// level register
	ipcirq_rst_e state;
	logic [15:0] cnt;
	logic load_done;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			level <= '0;
			load_done <= 1'b0;
		end else if (!load_done) begin
			level <= preset;
			load_done <= 1'b1;
		end else if (level_wr) begin
			level.first <= wdata[FLD_FIRST_LSB +: 3];
			level.second <= wdata[FLD_SECOND_LSB +: 3];
		end
	end
	// =========================================================
	// module reset sequencer
	wire start = ctrl_wr && wdata[BIT_RESET];
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= RST_IDLE;
			cnt <= '0;
		end else begin
			case (state)
				RST_IDLE: begin
					if (start) begin
						state <= RST_BUSY;
						cnt <= 16'(RESET_CYC - 1);
					end
				end
				RST_BUSY: begin
					if (cnt == '0) state <= RST_IDLE;
					else cnt <= cnt - 16'h0001;
				end
				default: state <= RST_IDLE;
			endcase
		end
	end
	assign mod_reset = (state == RST_BUSY);
	// =========================================================
	// status and request decode
	assign ctrl_rd = {mod_reset, RSV_FILL, mod_in.error,
		mod_in.irq};
	genvar g;
	generate
		for (g = 1; g < 8; g++) begin : g_lvl
			assign req_lines[g] =
				(mod_in.irq[0] && level.first == 3'(g)) ||
				(mod_in.irq[1] && level.second == 3'(g));
		end
	endgenerate
	assign req_lines[0] = 1'b0;

	// =========================================================
	// checks
	// length of the current module reset run, for the pulse check
	logic [15:0] busy_len;
	always_ff @(posedge core_clk) begin
		if (sys_rst) busy_len <= '0;
		else if (mod_reset) busy_len <= busy_len + 16'h0001;
		else busy_len <= '0;
	end
	property p_reset_start;
		@(posedge core_clk) disable iff (sys_rst)
		(state == RST_IDLE && start) |=> mod_reset;
	endproperty
	a_reset_start: assert property (p_reset_start)
		else $error("module reset did not start");
	property p_reset_len;
		@(posedge core_clk) disable iff (sys_rst)
		$fell(mod_reset) |-> busy_len == 16'(RESET_CYC);
	endproperty
	a_reset_len: assert property (p_reset_len)
		else $error("module reset length wrong");
	property p_zero_blocks;
		@(posedge core_clk) disable iff (sys_rst)
		(level.first == 3'h0 && level.second == 3'h0) |-> req_lines == '0;
	endproperty
	a_zero_blocks: assert property (p_zero_blocks)
		else $error("disabled level drives request");
endmodule : ipcirq_slot
`default_nettype wire

/* design/ipcirq_top.sv */
// Purpose: two-slot carrier interrupt level and control registers
// Assumes: A16 strobe-level access, one cycle per access, 10 MHz clock
// Notes: read data registered; ack one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module ipcirq_top
	import ipcirq_pkg::*;
#(
	parameter int RESET_CYC = MOD_RESET_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// configuration switch
	input wire logic [3:0] interrupt_map_selector_switch,
	// bus side
	input wire logic bus_strobe,
	input wire logic bus_a16,
	input wire logic bus_write,
	input wire logic [8:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	output logic bus_ack,
	output logic id_space_sel,
	output logic [6:0] vme_irq_req,
	// mezzanine slot a
	input wire ipcirq_mod_s mezzanine_slot_a,
	output logic slot_a_module_reset,
	// mezzanine slot b
	input wire ipcirq_mod_s mezzanine_slot_b,
	output logic slot_b_module_reset
);
	// =========================================================
	// input synchronisers
	logic [3:0] sel_m, sel;
	ipcirq_mod_s a_m, a_s, b_m, b_s;
	always_ff @(posedge core_clk) begin
		sel_m <= interrupt_map_selector_switch;
		sel <= sel_m;
		a_m <= mezzanine_slot_a;
		a_s <= a_m;
		b_m <= mezzanine_slot_b;
		b_s <= b_m;
	end
	// =========================================================
	// decode
	wire regs_on = !sel[3];
	wire in_reg = bus_addr[7:0] >= OFS_REG_LO;
	wire acc = bus_strobe && bus_a16 && regs_on;
	wire wr = acc && bus_write;
	wire a_lvl_hit = acc && bus_addr == OFS_SLOT_A_LEVEL;
	wire b_lvl_hit = acc && bus_addr == OFS_SLOT_B_LEVEL;
	wire a_ctl_hit = acc && bus_addr == OFS_SLOT_A_CTRL;
	wire b_ctl_hit = acc && bus_addr == OFS_SLOT_B_CTRL;
	assign id_space_sel = bus_strobe && bus_a16 && bus_addr[7:0] >= OFS_ID_LO
		&& !(regs_on && in_reg);
	// =========================================================
	// slots
	ipcirq_map_s a_lvl, b_lvl;
	logic [7:0] a_ctl, b_ctl, a_req, b_req;
	ipcirq_slot #(.RESET_CYC(RESET_CYC)) u_slot_a (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.preset(ipcirq_preset(sel[2:0], 1'b0)),
		.level_wr(wr && a_lvl_hit),
		.ctrl_wr(wr && a_ctl_hit),
		.wdata(bus_wdata),
		.mod_in(a_s),
		.mod_reset(slot_a_module_reset),
		.level(a_lvl),
		.ctrl_rd(a_ctl),
		.req_lines(a_req)
	);
	ipcirq_slot #(.RESET_CYC(RESET_CYC)) u_slot_b (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.preset(ipcirq_preset(sel[2:0], 1'b1)),
		.level_wr(wr && b_lvl_hit),
		.ctrl_wr(wr && b_ctl_hit),
		.wdata(bus_wdata),
		.mod_in(b_s),
		.mod_reset(slot_b_module_reset),
		.level(b_lvl),
		.ctrl_rd(b_ctl),
		.req_lines(b_req)
	);
	// =========================================================
	// read data and outputs
	wire [7:0] next_rdata =
		a_lvl_hit ? {1'b0, a_lvl.second, 1'b0, a_lvl.first} :
		b_lvl_hit ? {1'b0, b_lvl.second, 1'b0, b_lvl.first} :
		a_ctl_hit ? a_ctl :
		b_ctl_hit ? b_ctl : 8'h00;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bus_rdata <= 8'h00;
			bus_ack <= 1'b0;
			vme_irq_req <= 7'h00;
		end else begin
			bus_rdata <= next_rdata;
			bus_ack <= acc;
			vme_irq_req <= a_req[7:1] | b_req[7:1];
		end
	end

	// =========================================================
	// checks
	property p_off_no_ack;
		@(posedge core_clk) disable iff (sys_rst)
		(bus_strobe && sel[3]) |=> !bus_ack;
	endproperty
	a_off_no_ack: assert property (p_off_no_ack)
		else $error("registers answered while disabled");
	property p_err_read;
		@(posedge core_clk) disable iff (sys_rst)
		(a_ctl_hit && !bus_write) |=> bus_rdata[BIT_ERROR] == $past(a_s.error);
	endproperty
	a_err_read: assert property (p_err_read)
		else $error("error bit mismatch");
	property p_id_route;
		@(posedge core_clk) disable iff (sys_rst)
		(bus_strobe && bus_a16 && sel[3] && in_reg) |-> id_space_sel;
	endproperty
	a_id_route: assert property (p_id_route)
		else $error("id space not selected");
	property p_lvl_route;
		@(posedge core_clk) disable iff (sys_rst)
		(a_s.irq[0] && a_lvl.first != 3'h0) |=>
			vme_irq_req[$past(a_lvl.first) - 1];
	endproperty
	a_lvl_route: assert property (p_lvl_route)
		else $error("level not routed");
endmodule : ipcirq_top
`default_nettype wire

/* test/ipcirq_mezz.sv */
// Purpose: mezzanine module model, interrupt and error lines
// Assumes: lines active high, synchronous to core_clk
// Notes: a module reset drops every request it holds
`timescale 1ns/10ps
`default_nettype none
module ipcirq_mezz
	import ipcirq_pkg::*;
(
	// clock
	input wire logic core_clk,
	// control
	input wire logic mod_reset,
	input wire ipcirq_mod_s drive,
	// lines
	output ipcirq_mod_s mod_out
);
	// ==================================================
	// module lines
	always_ff @(posedge core_clk) begin
		mod_out <= mod_reset ? '0 : drive;
	end
endmodule : ipcirq_mezz
`default_nettype wire

/* test/ipcirq_top_tb.sv */
// Purpose: self-checking bench for the carrier level and control regs
// Assumes: switch at 2 through first reset, short module reset
// Notes: random data from xorshift seeded at 44
`timescale 1ns/10ps
`default_nettype none
module ipcirq_top_tb;
	import ipcirq_pkg::*;
	localparam int TB_RST_CYC = 4;
	logic core_clk, sys_rst, bus_strobe, bus_a16, bus_write;
	logic [3:0] sw, sv;
	logic [7:0] pa, pb;
	logic [8:0] bus_addr;
	logic [7:0] bus_wdata, bus_rdata, rd;
	logic bus_ack, id_space_sel, rst_a, rst_b, ok, id;
	logic [6:0] vme_irq_req;
	ipcirq_mod_s drv_a, drv_b, mod_a, mod_b;
	int err_count, check_count, n;
	logic [31:0] seed;
	ipcirq_top #(.RESET_CYC(TB_RST_CYC)) dut (.core_clk, .sys_rst,
		.interrupt_map_selector_switch(sw), .bus_strobe, .bus_a16,
		.bus_write, .bus_addr, .bus_wdata, .bus_rdata, .bus_ack,
		.id_space_sel, .vme_irq_req, .mezzanine_slot_a(mod_a),
		.slot_a_module_reset(rst_a), .mezzanine_slot_b(mod_b),
		.slot_b_module_reset(rst_b));
	ipcirq_mezz u_ma (.core_clk, .mod_reset(rst_a), .drive(drv_a),
		.mod_out(mod_a));
	ipcirq_mezz u_mb (.core_clk, .mod_reset(rst_b), .drive(drv_b),
		.mod_out(mod_b));
	// ==================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	function automatic logic [6:0] req_of(input logic [2:0] lv);
		return (lv == 3'h0) ? 7'h00 : 7'h01 << (lv - 3'h1);
	endfunction : req_of
	// level register contents after reset, per selector and slot
	function automatic logic [7:0] preset_of(input logic [3:0] s,
		input logic b);
		case ({b, s[2:0]})
			4'h1: return 8'h21;
			4'h2: return 8'h54;
			4'h3: return 8'h46;
			4'h4: return 8'h11;
			4'h9: return 8'h43;
			4'hA: return 8'h12;
			4'hB: return 8'h13;
			4'hC: return 8'h22;
			default: return 8'h00;
		endcase
	endfunction : preset_of
	task automatic chk(input string nm, input logic [7:0] s,
		input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic acc(input logic a16, input logic wr,
		input logic [8:0] ad, input logic [7:0] wd);
		@(posedge core_clk);
		bus_strobe <= 1'b1;
		bus_a16 <= a16;
		bus_write <= wr;
		bus_addr <= ad;
		bus_wdata <= wd;
		#1;
		id = id_space_sel;
		@(posedge core_clk);
		bus_strobe <= 1'b0;
		#1;
		ok = bus_ack;
		rd = bus_rdata;
	endtask : acc
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run
	// ==================================================
	// stimulus
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		sys_rst = 1'b1;
		bus_strobe = 1'b0;
		bus_a16 = 1'b0;
		bus_write = 1'b0;
		bus_addr = '0;
		bus_wdata = '0;
		sw = 4'h2;
		drv_a = '0;
		drv_b = '0;
		seed = 32'h2C;
		err_count = 0;
		check_count = 0;
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		acc(1, 0, OFS_SLOT_A_LEVEL, 8'h00);
		chk("lvl_a", rd, 8'h54);
		acc(1, 0, OFS_SLOT_B_LEVEL, 8'h00);
		chk("lvl_b", rd, 8'h12);
		acc(1, 0, OFS_SLOT_B_CTRL, 8'h00);
		chk("ctl_b", rd, CTRL_RESET_VAL);
		$display("reset values done");
		for (n = 0; n < 6; n++) begin
			seed = xs(seed);
			acc(1, 1, n[0] ? OFS_SLOT_B_LEVEL : OFS_SLOT_A_LEVEL, seed[7:0]);
			acc(1, 0, n[0] ? OFS_SLOT_B_LEVEL : OFS_SLOT_A_LEVEL, 8'h00);
			chk("lvl_rw", rd, seed[7:0] & LEVEL_WMASK);
			chk("ack", {7'h0, ok}, 8'h01);
		end
		$display("level access done");
		@(posedge core_clk);
		drv_a <= '{irq: 2'b01, error: 1'b1};
		drv_b <= '{irq: 2'b10, error: 1'b0};
		for (n = 0; n < 8; n++) begin
			acc(1, 1, OFS_SLOT_A_LEVEL, {5'h0, n[2:0]});
			acc(1, 1, OFS_SLOT_B_LEVEL, {1'b0, ~n[2:0], 4'h0});
			repeat (4) @(posedge core_clk);
			chk("irq", {1'b0, vme_irq_req},
				{1'b0, req_of(n[2:0]) | req_of(~n[2:0])});
		end
		acc(1, 0, OFS_SLOT_A_CTRL, 8'h00);
		chk("ctl_a", rd, 8'h05);
		acc(1, 0, OFS_SLOT_B_CTRL, 8'h00);
		chk("ctl_b", rd, 8'h02);
		$display("routing done");
		acc(1, 1, OFS_SLOT_A_CTRL, 8'hFF);
		chk("mrst", {7'h0, rst_a}, 8'h01);
		acc(1, 0, OFS_SLOT_A_CTRL, 8'h00);
		chk("busy", rd & 8'hF8, 8'h80);
		n = 0;
		do begin
			acc(1, 0, OFS_SLOT_A_CTRL, 8'h00);
			n++;
		end while (rd[7] === 1'b1 && n < 20);
		chk("poll", {7'h0, rd[7]}, 8'h00);
		chk("mrst_end", {7'h0, rst_a}, 8'h00);
		acc(1, 0, 9'h0C5, 8'h00);
		chk("unmap", rd, 8'h00);
		acc(0, 1, OFS_SLOT_A_LEVEL, 8'h33);
		chk("a24_ack", {7'h0, ok}, 8'h00);
		acc(1, 1, OFS_SLOT_A_CTRL, 8'h7F);
		chk("no_start", {7'h0, rst_a}, 8'h00);
		acc(1, 1, OFS_SLOT_B_CTRL, 8'h80);
		chk("mrst_b", {7'h0, rst_b}, 8'h01);
		for (n = 0; n < 20 && rst_b === 1'b1; n++) begin
			@(posedge core_clk);
			#1;
		end
		chk("mrst_b_len", n[7:0], 8'(TB_RST_CYC));
		$display("module reset done");
		@(posedge core_clk);
		sw <= 4'h8;
		repeat (5) @(posedge core_clk);
		acc(1, 1, OFS_SLOT_A_LEVEL, 8'h11);
		chk("off_ack", {7'h0, ok}, 8'h00);
		chk("id_sel", {7'h0, id}, 8'h01);
		sw <= 4'h2;
		repeat (5) @(posedge core_clk);
		acc(1, 0, OFS_SLOT_A_LEVEL, 8'h00);
		chk("kept", rd, 8'h07);
		chk("id_on", {7'h0, id}, 8'h00);
		$display("selector done");
		for (n = 0; n < 7; n++) begin
			sv = (n == 6) ? 4'hB : 4'(n);
			@(posedge core_clk);
			sw <= sv;
			repeat (4) @(posedge core_clk);
			sys_rst <= 1'b1;
			repeat (3) @(posedge core_clk);
			sys_rst <= 1'b0;
			repeat (4) @(posedge core_clk);
			pa = preset_of(sv, 1'b0);
			pb = preset_of(sv, 1'b1);
			chk("irq_rst", {1'b0, vme_irq_req},
				{1'b0, req_of(pa[2:0]) | req_of(pb[6:4])});
			if (!sv[3]) begin
				acc(1, 0, OFS_SLOT_A_LEVEL, 8'h00);
				chk("pre_a", rd, pa);
				acc(1, 0, OFS_SLOT_B_LEVEL, 8'h00);
				chk("pre_b", rd, pb);
			end
		end
		$display("preset done");
		complete_run();
	end
endmodule : ipcirq_top_tb
`default_nettype wire
